// ===== design/ptl_top.sv
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// ************************************************************
// transmit lane of the PHY interface with AXI4-Lite registers
// ************************************************************
module ptl_top #(
  parameter bit SIM_CONFIG = 1'b1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // register bus
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  // de-emphasis request seen during training
  input  wire logic        partner_deemph_valid,
  input  wire logic        partner_deemph,
  // PHY transmit lane
  output logic [31:0]      tx_data,
  output logic [3:0]       tx_datak,
  output logic             tx_dataskip,
  output logic             tx_blkst,
  output logic [1:0]       tx_synchd,
  output logic             tx_deemph,
  output logic             tx_detectrx,
  output logic             tx_elecidle,
  output logic [2:0]       tx_margin,
  output logic             tx_swing
);

  typedef enum logic [0:0] {PTL_W_IDLE, PTL_W_RESP} ptl_wstate_t;
  typedef enum logic [0:0] {PTL_R_IDLE, PTL_R_RESP} ptl_rstate_t;

  ptl_lane_if lane ();

  // ************************************************************
  // register state
  // ************************************************************
  logic [31:0] reg_ctrl;
  logic [31:0] reg_link_ctl2;
  logic [31:0] reg_tx_ctrl;
  logic [31:0] reg_tx_data;
  logic [15:0] word_count;
  logic [31:0] next_reg_ctrl;
  logic [31:0] next_reg_link_ctl2;
  logic [31:0] next_reg_tx_ctrl;
  logic [31:0] next_reg_tx_data;
  logic [15:0] next_word_count;

  // ************************************************************
  // write channel state
  // ************************************************************
  ptl_wstate_t wstate;
  ptl_wstate_t next_wstate;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        next_aw_held;
  logic        next_w_held;
  logic [7:0]  next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic [1:0]  next_bresp;
  logic        next_bvalid;
  logic        next_awready;
  logic        next_wready;
  logic        wr_fire;
  logic        send_now;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;

  // ************************************************************
  // read channel state
  // ************************************************************
  ptl_rstate_t rstate;
  ptl_rstate_t next_rstate;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_rvalid;
  logic        next_arready;
  logic [31:0] status_word;

  // write path: address and data taken in either order
  always_comb begin
    next_wstate  = wstate;
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bresp   = s_axil_bresp;
    next_bvalid  = s_axil_bvalid;
    wr_fire      = 1'b0;
    wr_addr      = aw_held ? aw_addr : s_axil_awaddr;
    wr_data      = w_held ? w_data : s_axil_wdata;
    wr_strb      = w_held ? w_strb : s_axil_wstrb;
    case (wstate)
      PTL_W_IDLE: begin
        if (s_axil_awvalid && s_axil_awready) begin
          next_aw_held = 1'b1;
          next_aw_addr = s_axil_awaddr;
        end
        if (s_axil_wvalid && s_axil_wready) begin
          next_w_held = 1'b1;
          next_w_data = s_axil_wdata;
          next_w_strb = s_axil_wstrb;
        end
        if ((aw_held || (s_axil_awvalid && s_axil_awready)) &&
            (w_held || (s_axil_wvalid && s_axil_wready))) begin
          wr_fire      = 1'b1;
          next_aw_held = 1'b0;
          next_w_held  = 1'b0;
          next_bvalid  = 1'b1;
          next_wstate  = PTL_W_RESP;
          case (wr_addr)
            ptl_pkg::ADDR_CTRL, ptl_pkg::ADDR_LINK_CTL2, ptl_pkg::ADDR_TX_CTRL,
            ptl_pkg::ADDR_TX_DATA: next_bresp = ptl_pkg::RESP_OKAY;
            default:               next_bresp = ptl_pkg::RESP_SLVERR;
          endcase
        end
      end
      PTL_W_RESP: begin
        if (s_axil_bready) begin
          next_bvalid = 1'b0;
          next_wstate = PTL_W_IDLE;
        end
      end
      default: begin
        next_wstate = PTL_W_IDLE;
        next_bvalid = 1'b0;
      end
    endcase
    next_awready = (next_wstate == PTL_W_IDLE) && !next_aw_held;
    next_wready  = (next_wstate == PTL_W_IDLE) && !next_w_held;
  end

  // register file updates
  always_comb begin
    next_reg_ctrl      = reg_ctrl;
    next_reg_link_ctl2 = reg_link_ctl2;
    next_reg_tx_ctrl   = reg_tx_ctrl;
    next_reg_tx_data   = reg_tx_data;
    next_word_count    = word_count;
    send_now           = 1'b0;
    if (wr_fire) begin
      case (wr_addr)
        ptl_pkg::ADDR_CTRL:      next_reg_ctrl      = ptl_pkg::ptl_merge(reg_ctrl, wr_data, wr_strb);
        ptl_pkg::ADDR_LINK_CTL2: next_reg_link_ctl2 = ptl_pkg::ptl_merge(reg_link_ctl2, wr_data, wr_strb);
        ptl_pkg::ADDR_TX_CTRL:   next_reg_tx_ctrl   = ptl_pkg::ptl_merge(reg_tx_ctrl, wr_data, wr_strb);
        ptl_pkg::ADDR_TX_DATA: begin
          next_reg_tx_data = ptl_pkg::ptl_merge(reg_tx_data, wr_data, wr_strb);
          send_now         = 1'b1;
          next_word_count  = word_count + 16'h0001;
        end
        default: send_now = 1'b0;
      endcase
    end
    // block start is a one-shot request, consumed by the word it goes with
    if (send_now) begin
      next_reg_tx_ctrl[ptl_pkg::TXC_BLK_START] = 1'b0;
    end
  end

  // status word built from lane state
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ptl_pkg::STAT_DEEMPH]                = lane.deemph;
    status_word[ptl_pkg::STAT_SYNC_LSB +: 2]         = lane.synchd;
    status_word[ptl_pkg::STAT_GEN3]                  = ptl_pkg::ptl_is_gen3(lane.rate);
    status_word[ptl_pkg::STAT_COUNT_LSB +: 16]       = word_count;
  end

  // read path: one read at a time, answered a cycle after it is taken
  always_comb begin
    next_rstate = rstate;
    next_rdata  = s_axil_rdata;
    next_rresp  = s_axil_rresp;
    next_rvalid = s_axil_rvalid;
    case (rstate)
      PTL_R_IDLE: begin
        if (s_axil_arvalid && s_axil_arready) begin
          next_rvalid = 1'b1;
          next_rstate = PTL_R_RESP;
          next_rresp  = ptl_pkg::RESP_OKAY;
          case (s_axil_araddr)
            ptl_pkg::ADDR_CTRL:      next_rdata = reg_ctrl;
            ptl_pkg::ADDR_LINK_CTL2: next_rdata = reg_link_ctl2;
            ptl_pkg::ADDR_TX_CTRL:   next_rdata = reg_tx_ctrl;
            ptl_pkg::ADDR_TX_DATA:   next_rdata = reg_tx_data;
            ptl_pkg::ADDR_STATUS:    next_rdata = status_word;
            default: begin
              next_rdata = 32'h0000_0000;
              next_rresp = ptl_pkg::RESP_SLVERR;
            end
          endcase
        end
      end
      PTL_R_RESP: begin
        if (s_axil_rready) begin
          next_rvalid = 1'b0;
          next_rstate = PTL_R_IDLE;
        end
      end
      default: begin
        next_rstate = PTL_R_IDLE;
        next_rvalid = 1'b0;
      end
    endcase
    next_arready = (next_rstate == PTL_R_IDLE);
  end

  // all bus and register flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate         <= PTL_W_IDLE;
      rstate         <= PTL_R_IDLE;
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      aw_addr        <= 8'h00;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      s_axil_awready <= 1'b0;
      s_axil_wready  <= 1'b0;
      s_axil_bvalid  <= 1'b0;
      s_axil_bresp   <= ptl_pkg::RESP_OKAY;
      s_axil_arready <= 1'b0;
      s_axil_rvalid  <= 1'b0;
      s_axil_rresp   <= ptl_pkg::RESP_OKAY;
      s_axil_rdata   <= 32'h0000_0000;
      reg_ctrl       <= ptl_pkg::RST_CTRL;
      reg_link_ctl2  <= ptl_pkg::RST_LINK_CTL2;
      reg_tx_ctrl    <= ptl_pkg::RST_TX_CTRL;
      reg_tx_data    <= ptl_pkg::RST_TX_DATA;
      word_count     <= 16'h0000;
    end else begin
      wstate         <= next_wstate;
      rstate         <= next_rstate;
      aw_held        <= next_aw_held;
      w_held         <= next_w_held;
      aw_addr        <= next_aw_addr;
      w_data         <= next_w_data;
      w_strb         <= next_w_strb;
      s_axil_awready <= next_awready;
      s_axil_wready  <= next_wready;
      s_axil_bvalid  <= next_bvalid;
      s_axil_bresp   <= next_bresp;
      s_axil_arready <= next_arready;
      s_axil_rvalid  <= next_rvalid;
      s_axil_rresp   <= next_rresp;
      s_axil_rdata   <= next_rdata;
      reg_ctrl       <= next_reg_ctrl;
      reg_link_ctl2  <= next_reg_link_ctl2;
      reg_tx_ctrl    <= next_reg_tx_ctrl;
      reg_tx_data    <= next_reg_tx_data;
      word_count     <= next_word_count;
    end
  end

  // ************************************************************
  // lane fields from the registers
  // ************************************************************
  assign lane.rate      = reg_ctrl[ptl_pkg::CTRL_RATE_LSB +: 2];
  assign lane.elecidle  = reg_ctrl[ptl_pkg::CTRL_ELECIDLE];
  assign lane.detectrx  = reg_ctrl[ptl_pkg::CTRL_DETECTRX];
  assign lane.swing     = reg_ctrl[ptl_pkg::CTRL_SWING];
  assign lane.margin    = reg_link_ctl2[ptl_pkg::LC2_MARGIN_LSB +: 3];
  assign lane.send      = send_now;
  assign lane.word      = next_reg_tx_data;
  assign lane.datak     = reg_tx_ctrl[ptl_pkg::TXC_DATAK_LSB +: 4];
  assign lane.blk_os    = reg_tx_ctrl[ptl_pkg::TXC_BLK_OS];
  assign lane.blk_start = reg_tx_ctrl[ptl_pkg::TXC_BLK_START];

  // ************************************************************
  // lane logic
  // ************************************************************
  ptl_tx_encoder u_enc (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .lane        (lane.enc),
    .tx_data     (tx_data),
    .tx_datak    (tx_datak),
    .tx_dataskip (tx_dataskip),
    .tx_blkst    (tx_blkst),
    .tx_synchd   (tx_synchd)
  );

  ptl_lane_ctl #(
    .SIM_CONFIG (SIM_CONFIG)
  ) u_ctl (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .lane                 (lane.ctl),
    .partner_deemph_valid (partner_deemph_valid),
    .partner_deemph       (partner_deemph),
    .tx_deemph            (tx_deemph),
    .tx_detectrx          (tx_detectrx),
    .tx_elecidle          (tx_elecidle),
    .tx_margin            (tx_margin),
    .tx_swing             (tx_swing)
  );

endmodule

// ===== design/ptl_pkg.sv
// Notes on behaviour
// - transmit payload leaves on a 32-bit parallel data output per lane.
// - four per-byte control flags, bit zero qualifies the lowest byte.
// - flag low marks a data byte, flag high marks a control byte.
// - per-byte flags only carry meaning at the first two rates.
// - at third rate a data-skip output makes the PHY ignore one cycle.
// - data-skip zero marks transmit data invalid, one marks it valid.
// - de-emphasis output follows partner request from training, no user action.
// - detect-receiver output starts receiver detection or loopback in the PHY.
// - electrical-idle output holds the lane transmitter in electrical idle.
// - 3-bit margin output follows margin field of second link control register.
// - margin output follows the field only in the simulation configuration, held at zero otherwise.
// - swing output high asks full swing, low asks half swing.
// - third rate sync header: 01 ordered set block, 10 data block.
// - third rate block-start output pulses when a new block begins.
package ptl_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_LINK_CTL2 = 8'h04;
  localparam logic [7:0] ADDR_TX_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_TX_DATA   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_RATE_LSB    = 0;
  localparam int CTRL_ELECIDLE    = 2;
  localparam int CTRL_DETECTRX    = 3;
  localparam int CTRL_SWING       = 4;
  localparam int LC2_MARGIN_LSB   = 7;
  localparam int TXC_DATAK_LSB    = 0;
  localparam int TXC_BLK_OS       = 4;
  localparam int TXC_BLK_START    = 5;
  localparam int STAT_DEEMPH      = 0;
  localparam int STAT_SYNC_LSB    = 1;
  localparam int STAT_GEN3        = 3;
  localparam int STAT_COUNT_LSB   = 16;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [31:0] RST_CTRL     = 32'h0000_0014;  // idle and full swing
  localparam logic [31:0] RST_LINK_CTL2 = 32'h0000_0000;
  localparam logic [31:0] RST_TX_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_TX_DATA  = 32'h0000_0000;

  // ************************************************************
  // encodings
  // ************************************************************
  localparam logic [1:0] SYNC_OS    = 2'b01;
  localparam logic [1:0] SYNC_DATA  = 2'b10;
  localparam logic       SKIP_INVAL = 1'b0;
  localparam logic       SKIP_VALID = 1'b1;
  localparam logic [1:0] RESP_OKAY  = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // byte-lane merge of a write into a held word
  function automatic logic [31:0] ptl_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // third rate is selected by the upper rate bit
  function automatic logic ptl_is_gen3(input logic [1:0] rate);
    return rate[1];
  endfunction

endpackage

// ===== design/ptl_lane_if.sv
`timescale 1ns/1ps
// ************************************************************
// register side to lane logic carrier
// ************************************************************
interface ptl_lane_if;
  logic [1:0]  rate;
  logic        send;       // one-cycle pulse: a word is written
  logic [31:0] word;
  logic [3:0]  datak;
  logic        blk_os;
  logic        blk_start;
  logic        elecidle;
  logic        detectrx;
  logic        swing;
  logic [2:0]  margin;
  logic        deemph;     // back to register side
  logic [1:0]  synchd;     // back to register side

  modport regs (output rate, send, word, datak, blk_os, blk_start, elecidle, detectrx, swing, margin,
                input deemph, synchd);
  modport enc  (input rate, send, word, datak, blk_os, blk_start, output synchd);
  modport ctl  (input elecidle, detectrx, swing, margin, output deemph);
endinterface

// ===== design/ptl_tx_encoder.sv
`timescale 1ns/1ps
// ************************************************************
// transmit data path of one lane
// ************************************************************
module ptl_tx_encoder (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  ptl_lane_if.enc    lane,
  output logic [31:0] tx_data,
  output logic [3:0]  tx_datak,
  output logic        tx_dataskip,
  output logic        tx_blkst,
  output logic [1:0]  tx_synchd
);

  logic [31:0] next_tx_data;
  logic [3:0]  next_tx_datak;
  logic        next_tx_dataskip;
  logic        next_tx_blkst;
  logic [1:0]  next_tx_synchd;
  logic        gen3;

  // next pin values from the send pulse
  always_comb begin
    gen3             = ptl_pkg::ptl_is_gen3(lane.rate);
    next_tx_data     = tx_data;
    next_tx_datak    = tx_datak;
    next_tx_dataskip = ptl_pkg::SKIP_VALID;
    next_tx_blkst    = 1'b0;
    next_tx_synchd   = tx_synchd;
    if (lane.send) begin
      next_tx_data  = lane.word;
      next_tx_datak = gen3 ? 4'h0 : lane.datak;
      if (gen3 && lane.blk_start) begin
        next_tx_blkst  = 1'b1;
        next_tx_synchd = lane.blk_os ? ptl_pkg::SYNC_OS : ptl_pkg::SYNC_DATA;
      end
    end else if (gen3) begin
      next_tx_dataskip = ptl_pkg::SKIP_INVAL;
    end
  end

  // pin registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_data     <= 32'h0000_0000;
      tx_datak    <= 4'h0;
      tx_dataskip <= ptl_pkg::SKIP_VALID;
      tx_blkst    <= 1'b0;
      tx_synchd   <= ptl_pkg::SYNC_DATA;
    end else begin
      tx_data     <= next_tx_data;
      tx_datak    <= next_tx_datak;
      tx_dataskip <= next_tx_dataskip;
      tx_blkst    <= next_tx_blkst;
      tx_synchd   <= next_tx_synchd;
    end
  end

  assign lane.synchd = tx_synchd;

endmodule

// ===== design/ptl_lane_ctl.sv
`timescale 1ns/1ps
// ************************************************************
// lane control outputs toward the PHY
// ************************************************************
module ptl_lane_ctl #(
  parameter bit SIM_CONFIG = 1'b1
) (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  ptl_lane_if.ctl    lane,
  input  wire logic  partner_deemph_valid,
  input  wire logic  partner_deemph,
  output logic       tx_deemph,
  output logic       tx_detectrx,
  output logic       tx_elecidle,
  output logic [2:0] tx_margin,
  output logic       tx_swing
);

  logic       next_tx_deemph;
  logic       next_tx_detectrx;
  logic       next_tx_elecidle;
  logic [2:0] next_tx_margin;
  logic       next_tx_swing;

  // next control values
  always_comb begin
    next_tx_deemph   = partner_deemph_valid ? partner_deemph : tx_deemph;
    next_tx_detectrx = lane.detectrx;
    next_tx_elecidle = lane.elecidle;
    next_tx_margin   = SIM_CONFIG ? lane.margin : 3'h0;
    next_tx_swing    = lane.swing;
  end

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_deemph   <= 1'b0;
      tx_detectrx <= 1'b0;
      tx_elecidle <= 1'b1;
      tx_margin   <= 3'h0;
      tx_swing    <= 1'b1;
    end else begin
      tx_deemph   <= next_tx_deemph;
      tx_detectrx <= next_tx_detectrx;
      tx_elecidle <= next_tx_elecidle;
      tx_margin   <= next_tx_margin;
      tx_swing    <= next_tx_swing;
    end
  end

  assign lane.deemph = tx_deemph;

endmodule

// ===== test/ptl_top_sva.sv
`timescale 1ns/1ps
// ************************************************************
// lane stream properties at the top ports
// ************************************************************
module ptl_top_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        partner_deemph_valid,
  input wire logic        partner_deemph,
  input wire logic [31:0] tx_data,
  input wire logic [3:0]  tx_datak,
  input wire logic        tx_dataskip,
  input wire logic        tx_blkst,
  input wire logic [1:0]  tx_synchd,
  input wire logic        tx_deemph
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_blk_pulse; tx_blkst |=> !tx_blkst; endproperty
  a_blk_pulse: assert property (p_blk_pulse) else $error("block start longer than one cycle");
  property p_sync_code; tx_blkst |-> tx_synchd inside {2'b01, 2'b10}; endproperty
  a_sync_code: assert property (p_sync_code) else $error("bad sync header code");
  property p_sync_hold; !tx_blkst |-> $stable(tx_synchd); endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync header moved inside a block");
  property p_datak_gen3; tx_blkst |-> tx_datak == 4'h0; endproperty
  a_datak_gen3: assert property (p_datak_gen3) else $error("control flags set at third rate");
  property p_skip_blk; tx_blkst |-> tx_dataskip == 1'b1; endproperty
  a_skip_blk: assert property (p_skip_blk) else $error("block start word not marked valid");
  property p_skip_gap; tx_blkst |=> tx_dataskip == 1'b0; endproperty
  a_skip_gap: assert property (p_skip_gap) else $error("idle cycle not marked invalid");
  property p_data_skip; $changed(tx_data) |-> tx_dataskip; endproperty
  a_data_skip: assert property (p_data_skip) else $error("new word while marked invalid");
  property p_deemph; partner_deemph_valid |=> tx_deemph == $past(partner_deemph); endproperty
  a_deemph: assert property (p_deemph) else $error("de-emphasis not taken from partner");

  // main scenarios
  c_os_blk: cover property (tx_blkst && tx_synchd == 2'b01);
  c_data_blk: cover property (tx_blkst && tx_synchd == 2'b10);
  c_deemph: cover property (partner_deemph_valid && partner_deemph);
endmodule

// ===== test/ptl_phy_model.sv
`timescale 1ns/1ps
// ************************************************************
// behavioural PHY lane receiving the transmit stream
// ************************************************************
module ptl_phy_model (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] tx_data,
  input wire logic [3:0]  tx_datak,
  input wire logic        tx_dataskip,
  input wire logic        tx_blkst,
  input wire logic [1:0]  tx_synchd,
  input wire logic        tx_detectrx,
  input wire logic        tx_elecidle,
  input wire logic        tx_swing,
  output logic            line_idle,
  output logic            detecting,
  output logic            full_swing
);
  logic [31:0] word;
  logic [3:0]  k;
  logic [1:0]  hd;
  int          n_blk;
  int          n_skip;

  // take a word only when marked valid, count ignored cycles
  always @(posedge aclk) begin
    if (!aresetn) begin
      word <= 32'h0;
      k <= 4'h0;
      hd <= 2'b00;
      n_blk <= 0;
      n_skip <= 0;
    end else begin
      if (tx_dataskip) begin
        word <= tx_data;
        k <= tx_datak;
      end else begin
        n_skip <= n_skip + 1;
      end
      if (tx_blkst) begin
        hd <= tx_synchd;
        n_blk <= n_blk + 1;
      end
    end
  end

  // line state follows the control levels
  assign line_idle  = tx_elecidle;
  assign detecting  = tx_detectrx;
  assign full_swing = tx_swing;
endmodule

// ===== test/ptl_top_test.sv
`timescale 1ns/1ps
// ************************************************************
// self-checking bench for the transmit lane
// ************************************************************
module ptl_top_test;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
  logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata, tx_data, d;
  logic [3:0]  s_axil_wstrb = 4'hf, tx_datak;
  logic        s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
  logic        s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
  logic        partner_deemph_valid = 1'b0, partner_deemph = 1'b0;
  logic        s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [1:0]  s_axil_bresp, s_axil_rresp, tx_synchd, r;
  logic        tx_dataskip, tx_blkst, tx_deemph, tx_detectrx, tx_elecidle, tx_swing;
  logic [2:0]  tx_margin;
  int          err_total = 0, n_tests = 0, cyc = 0;

  ptl_top i_ptl_top (.*);
  ptl_phy_model i_ptl_phy_model (.aclk, .aresetn, .tx_data, .tx_datak, .tx_dataskip, .tx_blkst,
    .tx_synchd, .tx_detectrx, .tx_elecidle, .tx_swing, .line_idle(), .detecting(), .full_swing());

  // clock and cycle ceiling
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // write: address and data offered together, bready held until response
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axil_awvalid && s_axil_awready === 1'b1) s_axil_awvalid <= 1'b0;
      if (s_axil_wvalid && s_axil_wready === 1'b1) s_axil_wvalid <= 1'b0;
    end while (s_axil_bvalid !== 1'b1);
    r = s_axil_bresp;
    s_axil_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axil_arvalid && s_axil_arready === 1'b1) s_axil_arvalid <= 1'b0;
    end while (s_axil_rvalid !== 1'b1);
    d = s_axil_rdata;
    r = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk(r, ptl_pkg::RESP_OKAY);
  endtask

  // reset levels and control register default
  task automatic t_reset();
    @(negedge aclk);
    chk(tx_dataskip, 1'b1);
    chk(i_ptl_phy_model.line_idle, 1'b1);
    chk(i_ptl_phy_model.full_swing, 1'b1);
    chk(tx_synchd, ptl_pkg::SYNC_DATA);
    axr(ptl_pkg::ADDR_CTRL, d, r);
    chk(d, ptl_pkg::RST_CTRL);
  endtask

  // detect, idle and swing levels both ways
  task automatic t_ctrl();
    logic [31:0] v [2] = '{32'h08, 32'h14};
    foreach (v[i]) begin
      wr(ptl_pkg::ADDR_CTRL, v[i]);
      repeat (2) @(negedge aclk);
      chk(i_ptl_phy_model.detecting, v[i][3]);
      chk(i_ptl_phy_model.line_idle, v[i][2]);
      chk(i_ptl_phy_model.full_swing, v[i][4]);
    end
  endtask

  task automatic t_margin();
    wr(ptl_pkg::ADDR_LINK_CTL2, 32'h0000_0280);
    repeat (2) @(negedge aclk);
    chk(tx_margin, 3'h5);
  endtask

  // second rate: per-byte flags passed through, block start ignored
  task automatic t_gen2();
    int nb;
    wr(ptl_pkg::ADDR_CTRL, 32'h11);
    wr(ptl_pkg::ADDR_TX_CTRL, 32'h25);
    nb = i_ptl_phy_model.n_blk;
    wr(ptl_pkg::ADDR_TX_DATA, 32'ha1b2_c3d4);
    repeat (2) @(negedge aclk);
    chk(tx_data, 32'ha1b2_c3d4);
    chk(tx_datak, 4'h5);
    chk(tx_dataskip, 1'b1);
    chk(i_ptl_phy_model.n_blk, nb);
  endtask

  // third rate: ordered set block, data block, word inside a block
  task automatic t_gen3();
    int nb, ns;
    wr(ptl_pkg::ADDR_CTRL, 32'h12);
    nb = i_ptl_phy_model.n_blk;
    wr(ptl_pkg::ADDR_TX_CTRL, 32'h30);
    wr(ptl_pkg::ADDR_TX_DATA, 32'h5a5a_0f0f);
    repeat (2) @(negedge aclk);
    ns = i_ptl_phy_model.n_skip;
    chk(i_ptl_phy_model.word, 32'h5a5a_0f0f);
    chk(i_ptl_phy_model.hd, ptl_pkg::SYNC_OS);
    chk(i_ptl_phy_model.n_blk, nb + 1);
    wr(ptl_pkg::ADDR_TX_CTRL, 32'h2f);
    wr(ptl_pkg::ADDR_TX_DATA, 32'h1234_abcd);
    repeat (2) @(negedge aclk);
    chk(i_ptl_phy_model.hd, ptl_pkg::SYNC_DATA);
    chk(i_ptl_phy_model.k, 4'h0);
    chk(i_ptl_phy_model.n_skip > ns + 2, 1'b1);
    wr(ptl_pkg::ADDR_TX_DATA, 32'h0bad_f00d);
    repeat (2) @(negedge aclk);
    chk(i_ptl_phy_model.n_blk, nb + 2);
    axr(ptl_pkg::ADDR_STATUS, d, r);
    chk(d[3:1], 3'b110);
  endtask

  // partner request taken only while its strobe is high
  task automatic t_deemph();
    @(posedge aclk);
    partner_deemph_valid <= 1'b1;
    partner_deemph <= 1'b1;
    @(posedge aclk);
    partner_deemph_valid <= 1'b0;
    partner_deemph <= 1'b0;
    repeat (3) @(negedge aclk);
    chk(tx_deemph, 1'b1);
  endtask

  // unmapped and read-only places
  task automatic t_err();
    axw(8'h14, 32'hffff_ffff, r);
    chk(r, ptl_pkg::RESP_SLVERR);
    axw(ptl_pkg::ADDR_STATUS, 32'h0, r);
    chk(r, ptl_pkg::RESP_SLVERR);
    axr(8'h14, d, r);
    chk(r, ptl_pkg::RESP_SLVERR);
    chk(d, 32'h0);
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_ctrl();
    t_margin();
    t_gen2();
    t_gen3();
    t_deemph();
    t_err();
    end_sim();
  end
endmodule

bind ptl_top ptl_top_sva i_ptl_top_sva (.*);
